// ==== common/flag_bank_pkg.sv ====
// package: register map, field positions and reset values of the flag bank
package flag_bank_pkg;
  localparam int ADDR_W = 8;
  localparam int FLAG_W = 16;
  localparam int NUM_REGS = 3;
  // byte offsets on the register bus
  localparam logic [7:0] OFF_FLAGS_0 = 8'h00;
  localparam logic [7:0] OFF_FLAGS_1 = 8'h04;
  localparam logic [7:0] OFF_FLAGS_2 = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;
  // implemented flag positions, index 0 is the first register
  localparam logic [2:0][15:0] IMPL_MASK = {16'h3FE3, 16'hFEDF, 16'h3FEF};
  localparam logic [15:0] FLAG_RST = 16'h0000;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // first flag register
  localparam int POS_ADC_DONE = 13;
  localparam int POS_UART_A_TX = 12;
  localparam int POS_UART_A_RX = 11;
  localparam int POS_SPI_A_EVENT = 10;
  localparam int POS_SPI_A_FAULT = 9;
  localparam int POS_TIMER_C = 8;
  localparam int POS_TIMER_B = 7;
  localparam int POS_COMPARE_B = 6;
  localparam int POS_CAPTURE_B = 5;
  localparam int POS_TIMER_A = 3;
  localparam int POS_COMPARE_A = 2;
  localparam int POS_CAPTURE_A = 1;
  localparam int POS_EXT_PIN_A = 0;
  // second flag register
  localparam int POS_UART_B_TX = 15;
  localparam int POS_UART_B_RX = 14;
  localparam int POS_EXT_PIN_C = 13;
  localparam int POS_TIMER_E = 12;
  localparam int POS_TIMER_D = 11;
  localparam int POS_COMPARE_D = 10;
  localparam int POS_COMPARE_C = 9;
  localparam int POS_CAPTURE_H = 7;
  localparam int POS_CAPTURE_G = 6;
  localparam int POS_EXT_PIN_B = 4;
  localparam int POS_PIN_CHANGE = 3;
  localparam int POS_COMPARATOR = 2;
  localparam int POS_I2C_A_MASTER = 1;
  localparam int POS_I2C_A_SLAVE = 0;
  // third flag register
  localparam int POS_PARALLEL_PORT = 13;
  localparam int POS_COMPARE_H = 12;
  localparam int POS_COMPARE_G = 11;
  localparam int POS_COMPARE_F = 10;
  localparam int POS_COMPARE_E = 9;
  localparam int POS_CAPTURE_F = 8;
  localparam int POS_CAPTURE_E = 7;
  localparam int POS_CAPTURE_D = 6;
  localparam int POS_CAPTURE_C = 5;
  localparam int POS_SPI_B_EVENT = 1;
  localparam int POS_SPI_B_FAULT = 0;
endpackage

// ==== common/flag_bus_if.sv ====
// interface between bus front end and flag storage
`timescale 1ns/10ps
interface flag_bus_if;
  logic [2:0] wr_sel;
  logic [15:0] wr_data;
  logic [15:0] wr_mask;
  logic [2:0][15:0] set;
  logic [2:0][15:0] flags;
  logic [2:0] raised;
  modport bank (input wr_sel, input wr_data, input wr_mask, input set, output flags, output raised);
  modport ctl (output wr_sel, output wr_data, output wr_mask, output set, input flags, input raised);
endinterface

// ==== hw/flag_store.sv ====
// three flag registers with request set and software write
`timescale 1ns/10ps
module flag_store (
  input wire logic aclk,
  input wire logic aresetn,
  flag_bus_if.bank fb
);
  typedef struct packed {
    logic [2:0][15:0] flags;
  } store_t;

  store_t s;
  store_t next_s;
  logic [2:0][15:0] upd;
  logic [2:0] rise;

  genvar i;
  generate
    for (i = 0; i < flag_bank_pkg::NUM_REGS; i++) begin : g_reg
      logic [15:0] wm;
      assign wm = fb.wr_sel[i] ? fb.wr_mask : 16'h0000;
      assign upd[i] = ((s.flags[i] & ~wm) | (fb.wr_data & wm) | fb.set[i]) & flag_bank_pkg::IMPL_MASK[i];
      // a new request latched into a clear flag
      assign rise[i] = |(fb.set[i] & ~s.flags[i] & flag_bank_pkg::IMPL_MASK[i]);
    end
  endgenerate

  always_comb begin
    next_s = s;
    next_s.flags = upd;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s.flags <= {3{flag_bank_pkg::FLAG_RST}};
    end else begin
      s <= next_s;
    end
  end

  assign fb.flags = s.flags;
  assign fb.raised = rise;
endmodule

// ==== hw/flag_bank.sv ====
// interrupt flag status bank with AXI4-Lite register access
`timescale 1ns/10ps
// Overview of operation
// - a flag reads 1 once its source has requested or software has written 1, and stays 1 until software writes 0.
// - every implemented flag is readable and writable by software and is 0 after reset.
// - unimplemented bit positions ignore writes and read as 0.
// - first register bits 13..8 are adc done, uart a tx, uart a rx, spi a event, spi a fault, timer c.
// - first register bits 7,6,5,3,2,1,0 are timer b, compare b, capture b, timer a, compare a, capture a, pin a.
// - second register bits 15..9 are uart b tx, uart b rx, pin c, timer e, timer d, compare d, compare c.
// - second register bits 7,6,4,3,2,1,0 are capture h, capture g, pin b, pin change, comparator, i2c master, slave.
// - third register bits 13..8 are parallel port, compare h, g, f, e and capture f.
// - third register bits 7,6,5,1,0 are capture e, d, c, spi b event and spi b fault.
// - sources sit in ascending vector order, so pin a is bit 0 of the first register.
module flag_bank (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [flag_bank_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [flag_bank_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic adc_done_req,
  input wire logic uart_a_tx_req,
  input wire logic uart_a_rx_req,
  input wire logic spi_a_event_req,
  input wire logic spi_a_fault_req,
  input wire logic timer_c_req,
  input wire logic timer_b_req,
  input wire logic compare_b_req,
  input wire logic capture_b_req,
  input wire logic timer_a_req,
  input wire logic compare_a_req,
  input wire logic capture_a_req,
  input wire logic ext_pin_a_req,
  input wire logic uart_b_tx_req,
  input wire logic uart_b_rx_req,
  input wire logic ext_pin_c_req,
  input wire logic timer_e_req,
  input wire logic timer_d_req,
  input wire logic compare_d_req,
  input wire logic compare_c_req,
  input wire logic capture_h_req,
  input wire logic capture_g_req,
  input wire logic ext_pin_b_req,
  input wire logic pin_change_req,
  input wire logic comparator_req,
  input wire logic i2c_a_master_req,
  input wire logic i2c_a_slave_req,
  input wire logic parallel_port_req,
  input wire logic compare_h_req,
  input wire logic compare_g_req,
  input wire logic compare_f_req,
  input wire logic compare_e_req,
  input wire logic capture_f_req,
  input wire logic capture_e_req,
  input wire logic capture_d_req,
  input wire logic capture_c_req,
  input wire logic spi_b_event_req,
  input wire logic spi_b_fault_req,
  output logic [15:0] irq_flags_0,
  output logic [15:0] irq_flags_1,
  output logic [15:0] irq_flags_2,
  output logic irq
);
  typedef enum logic [2:0] {
    WR_COLLECT = 3'b001,
    WR_APPLY = 3'b010,
    WR_RESP = 3'b100
  } wr_state_t;

  typedef struct packed {
    wr_state_t wstate;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [flag_bank_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] irq_status;
    logic [2:0] irq_enable;
    logic irq;
  } bank_state_t;

  localparam bank_state_t STATE_RST = '{
    wstate: WR_COLLECT,
    awready: 1'b0,
    wready: 1'b0,
    aw_got: 1'b0,
    w_got: 1'b0,
    aw_addr: '0,
    w_data: 32'h00000000,
    w_strb: 4'h0,
    bvalid: 1'b0,
    bresp: flag_bank_pkg::RESP_OKAY,
    arready: 1'b0,
    rvalid: 1'b0,
    rdata: 32'h00000000,
    rresp: flag_bank_pkg::RESP_OKAY,
    irq_status: flag_bank_pkg::IRQ_RST,
    irq_enable: flag_bank_pkg::IRQ_RST,
    irq: 1'b0
  };

  bank_state_t s;
  bank_state_t next_s;
  flag_bus_if fb ();
  logic [2:0][15:0] req;
  logic [2:0] irq_clr;
  logic [flag_bank_pkg::ADDR_W-1:0] wa;
  logic [flag_bank_pkg::ADDR_W-1:0] ra;

  flag_store u_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .fb(fb)
  );

  // source requests onto their flag positions
  always_comb begin
    req = '0;
    // vector order from bit 0 up
    req[0][flag_bank_pkg::POS_EXT_PIN_A] = ext_pin_a_req;
    req[0][flag_bank_pkg::POS_CAPTURE_A] = capture_a_req;
    req[0][flag_bank_pkg::POS_COMPARE_A] = compare_a_req;
    req[0][flag_bank_pkg::POS_TIMER_A] = timer_a_req;
    req[0][flag_bank_pkg::POS_CAPTURE_B] = capture_b_req;
    req[0][flag_bank_pkg::POS_COMPARE_B] = compare_b_req;
    req[0][flag_bank_pkg::POS_TIMER_B] = timer_b_req;
    req[0][flag_bank_pkg::POS_TIMER_C] = timer_c_req;
    req[0][flag_bank_pkg::POS_SPI_A_FAULT] = spi_a_fault_req;
    req[0][flag_bank_pkg::POS_SPI_A_EVENT] = spi_a_event_req;
    req[0][flag_bank_pkg::POS_UART_A_RX] = uart_a_rx_req;
    req[0][flag_bank_pkg::POS_UART_A_TX] = uart_a_tx_req;
    req[0][flag_bank_pkg::POS_ADC_DONE] = adc_done_req;
    req[1][flag_bank_pkg::POS_I2C_A_SLAVE] = i2c_a_slave_req;
    req[1][flag_bank_pkg::POS_I2C_A_MASTER] = i2c_a_master_req;
    req[1][flag_bank_pkg::POS_COMPARATOR] = comparator_req;
    req[1][flag_bank_pkg::POS_PIN_CHANGE] = pin_change_req;
    req[1][flag_bank_pkg::POS_EXT_PIN_B] = ext_pin_b_req;
    req[1][flag_bank_pkg::POS_CAPTURE_G] = capture_g_req;
    req[1][flag_bank_pkg::POS_CAPTURE_H] = capture_h_req;
    req[1][flag_bank_pkg::POS_COMPARE_C] = compare_c_req;
    req[1][flag_bank_pkg::POS_COMPARE_D] = compare_d_req;
    req[1][flag_bank_pkg::POS_TIMER_D] = timer_d_req;
    req[1][flag_bank_pkg::POS_TIMER_E] = timer_e_req;
    req[1][flag_bank_pkg::POS_EXT_PIN_C] = ext_pin_c_req;
    req[1][flag_bank_pkg::POS_UART_B_RX] = uart_b_rx_req;
    req[1][flag_bank_pkg::POS_UART_B_TX] = uart_b_tx_req;
    req[2][flag_bank_pkg::POS_SPI_B_FAULT] = spi_b_fault_req;
    req[2][flag_bank_pkg::POS_SPI_B_EVENT] = spi_b_event_req;
    req[2][flag_bank_pkg::POS_CAPTURE_C] = capture_c_req;
    req[2][flag_bank_pkg::POS_CAPTURE_D] = capture_d_req;
    req[2][flag_bank_pkg::POS_CAPTURE_E] = capture_e_req;
    req[2][flag_bank_pkg::POS_CAPTURE_F] = capture_f_req;
    req[2][flag_bank_pkg::POS_COMPARE_E] = compare_e_req;
    req[2][flag_bank_pkg::POS_COMPARE_F] = compare_f_req;
    req[2][flag_bank_pkg::POS_COMPARE_G] = compare_g_req;
    req[2][flag_bank_pkg::POS_COMPARE_H] = compare_h_req;
    req[2][flag_bank_pkg::POS_PARALLEL_PORT] = parallel_port_req;
  end

  // requests reach the flags with no enable gating
  assign fb.set = req;
  assign wa = {s.aw_addr[flag_bank_pkg::ADDR_W-1:2], 2'b00};
  assign ra = {araddr[flag_bank_pkg::ADDR_W-1:2], 2'b00};

  always_comb begin
    next_s = s;
    fb.wr_sel = 3'b000;
    fb.wr_data = s.w_data[15:0];
    fb.wr_mask = {{8{s.w_strb[1]}}, {8{s.w_strb[0]}}};
    irq_clr = 3'b000;
    // address and data are taken independently, in either order
    if (s.awready && awvalid) begin
      next_s.aw_addr = awaddr;
      next_s.aw_got = 1'b1;
    end
    if (s.wready && wvalid) begin
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
      next_s.w_got = 1'b1;
    end
    case (s.wstate)
      WR_COLLECT: begin
        if (next_s.aw_got && next_s.w_got) begin
          next_s.wstate = WR_APPLY;
        end
      end
      WR_APPLY: begin
        next_s.bresp = flag_bank_pkg::RESP_OKAY;
        case (wa)
          // software write to a flag register
          flag_bank_pkg::OFF_FLAGS_0: fb.wr_sel = 3'b001;
          flag_bank_pkg::OFF_FLAGS_1: fb.wr_sel = 3'b010;
          flag_bank_pkg::OFF_FLAGS_2: fb.wr_sel = 3'b100;
          flag_bank_pkg::OFF_IRQ_STATUS: begin
            // read-only, write accepted and dropped
          end
          flag_bank_pkg::OFF_IRQ_CLEAR: begin
            if (s.w_strb[0]) begin
              irq_clr = s.w_data[2:0];
            end
          end
          flag_bank_pkg::OFF_IRQ_ENABLE: begin
            if (s.w_strb[0]) begin
              next_s.irq_enable = s.w_data[2:0];
            end
          end
          default: next_s.bresp = flag_bank_pkg::RESP_DECERR;
        endcase
        next_s.aw_got = 1'b0;
        next_s.w_got = 1'b0;
        next_s.bvalid = 1'b1;
        next_s.wstate = WR_RESP;
      end
      WR_RESP: begin
        if (bready) begin
          next_s.bvalid = 1'b0;
          next_s.wstate = WR_COLLECT;
        end
      end
      default: next_s.wstate = WR_COLLECT;
    endcase
    // readies are registered, so a new address waits one cycle after a response
    next_s.awready = (next_s.wstate == WR_COLLECT) && !next_s.aw_got;
    next_s.wready = (next_s.wstate == WR_COLLECT) && !next_s.w_got;

    // read: data sampled at the address handshake, answered next cycle
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s.arready && arvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = flag_bank_pkg::RESP_OKAY;
      next_s.rdata = 32'h00000000;
      case (ra)
        // flags read with unused bits at 0
        flag_bank_pkg::OFF_FLAGS_0: next_s.rdata[15:0] = fb.flags[0];
        flag_bank_pkg::OFF_FLAGS_1: next_s.rdata[15:0] = fb.flags[1];
        flag_bank_pkg::OFF_FLAGS_2: next_s.rdata[15:0] = fb.flags[2];
        flag_bank_pkg::OFF_IRQ_STATUS: next_s.rdata[2:0] = s.irq_status;
        flag_bank_pkg::OFF_IRQ_CLEAR: next_s.rdata[2:0] = 3'h0;
        flag_bank_pkg::OFF_IRQ_ENABLE: next_s.rdata[2:0] = s.irq_enable;
        default: next_s.rresp = flag_bank_pkg::RESP_DECERR;
      endcase
    end
    next_s.arready = !next_s.rvalid;

    // sticky per-register events; a new request beats a clear in the same cycle
    next_s.irq_status = (s.irq_status & ~irq_clr) | fb.raised;
    // irq follows the next status so it falls with the clear, not a cycle later
    next_s.irq = |(next_s.irq_status & next_s.irq_enable);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign irq = s.irq;
  assign irq_flags_0 = fb.flags[0];
  assign irq_flags_1 = fb.flags[1];
  assign irq_flags_2 = fb.flags[2];
endmodule

// ==== sim/flag_bank_monitor.sv ====
// assertion checker watching the flag bank ports
`timescale 1ns/10ps
module flag_bank_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic ext_pin_a_req,
  input wire logic uart_b_tx_req,
  input wire logic parallel_port_req,
  input wire logic [15:0] irq_flags_0,
  input wire logic [15:0] irq_flags_1,
  input wire logic [15:0] irq_flags_2
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // either half of a write taken; the later one starts the apply cycle
  wire wr_hs = (awvalid && awready) || (wvalid && wready);
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_resp_late;
    !bvalid ##1 bvalid;
  endsequence
  property p_wr_resp;
    s_wr_taken |=> s_resp_late;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response timing wrong");
  property p_rd_resp;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read data not one cycle after address");
  property p_rst;
    $rose(aresetn) |-> (irq_flags_0 | irq_flags_1 | irq_flags_2) == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("flags not zero after reset");
  property p_unimpl;
    (irq_flags_0 & 16'hC010) == 16'h0000 && (irq_flags_1 & 16'h0120) == 16'h0000
      && (irq_flags_2 & 16'hC01C) == 16'h0000;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented flag bit set");
  // a flag may only drop two edges after a software write is taken
  property p_sticky;
    $past(aresetn) && ((($past(irq_flags_0) & ~irq_flags_0) | ($past(irq_flags_1) & ~irq_flags_1)
      | ($past(irq_flags_2) & ~irq_flags_2)) != 16'h0000) |-> $past(wr_hs, 2);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without a write");
  property p_pin_a;
    ext_pin_a_req |=> irq_flags_0[0];
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin a flag not set");
  property p_uart_b;
    uart_b_tx_req |=> irq_flags_1[15];
  endproperty
  a_uart_b: assert property (p_uart_b) else $error("uart b tx flag not set");
  property p_par;
    parallel_port_req |=> irq_flags_2[13];
  endproperty
  a_par: assert property (p_par) else $error("parallel port flag not set");
endmodule
bind flag_bank flag_bank_monitor mon_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .ext_pin_a_req(ext_pin_a_req), .uart_b_tx_req(uart_b_tx_req), .parallel_port_req(parallel_port_req),
  .irq_flags_0(irq_flags_0), .irq_flags_1(irq_flags_1), .irq_flags_2(irq_flags_2));

// ==== sim/source_model.sv ====
// peripheral request sources, bit r*16+p feeds flag register r position p
`timescale 1ns/10ps
module source_model (
  input wire logic aclk,
  output logic [47:0] req
);
  initial req = 48'h000000000000;
  task automatic pulse(input logic [47:0] v);
    @(posedge aclk);
    req <= v;
    @(posedge aclk);
    req <= 48'h000000000000;
  endtask
endmodule

// ==== sim/test_flag_bank.sv ====
// self-checking bench for the flag bank
`timescale 1ns/10ps
module test_flag_bank;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF, wr_strb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] f0, f1, f2;
  wire [47:0] q;
  wire [47:0] fo = {f2, f1, f0};
  logic [15:0] msk [3] = '{16'h3FEF, 16'hFEDF, 16'h3FE3};
  logic [15:0] exp_f [3] = '{16'h0000, 16'h0000, 16'h0000};
  int mismatches = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h00000057;
  always #2.5 aclk = ~aclk;
  source_model src_u (.aclk(aclk), .req(q));
  flag_bank dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq_flags_0(f0), .irq_flags_1(f1), .irq_flags_2(f2),
    .irq(irq),
    .adc_done_req(q[13]), .uart_a_tx_req(q[12]), .uart_a_rx_req(q[11]), .spi_a_event_req(q[10]),
    .spi_a_fault_req(q[9]), .timer_c_req(q[8]),
    .timer_b_req(q[7]), .compare_b_req(q[6]), .capture_b_req(q[5]), .timer_a_req(q[3]), .compare_a_req(q[2]),
    .capture_a_req(q[1]), .ext_pin_a_req(q[0]),
    .uart_b_tx_req(q[31]), .uart_b_rx_req(q[30]), .ext_pin_c_req(q[29]), .timer_e_req(q[28]),
    .timer_d_req(q[27]), .compare_d_req(q[26]), .compare_c_req(q[25]),
    .capture_h_req(q[23]), .capture_g_req(q[22]), .ext_pin_b_req(q[20]), .pin_change_req(q[19]),
    .comparator_req(q[18]), .i2c_a_master_req(q[17]), .i2c_a_slave_req(q[16]),
    .parallel_port_req(q[45]), .compare_h_req(q[44]), .compare_g_req(q[43]), .compare_f_req(q[42]),
    .compare_e_req(q[41]), .capture_f_req(q[40]),
    .capture_e_req(q[39]), .capture_d_req(q[38]), .capture_c_req(q[37]), .spi_b_event_req(q[33]),
    .spi_b_fault_req(q[32]));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= wr_strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic chk_all();
    logic [31:0] d;
    logic [1:0] rs;
    @(negedge aclk);
    for (int r = 0; r < 3; r++) begin
      chk("flag_out", {16'h0000, fo[r*16+:16]}, {16'h0000, exp_f[r]});
      rd(8'(r * 4), d, rs);
      chk("flag_read", d, {16'h0000, exp_f[r]});
      chk("read_resp", {30'h0, rs}, 32'h00000000);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // tests need under two thousand cycles, this leaves a wide margin
  initial begin
    repeat (50000) @(posedge aclk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] rs;
    logic [47:0] v;
    logic [15:0] sm;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    chk_all();
    chk("irq_reset", {31'h0, irq}, 32'h00000000);
    $display("reset test done");
    // enable left off, every position pulsed alone
    for (int i = 0; i < 48; i++) begin
      src_u.pulse(48'h000000000001 << i);
      exp_f[i / 16] = exp_f[i / 16] | (msk[i / 16] & (16'h0001 << (i % 16)));
      chk_all();
      wr(8'(i / 16 * 4), 32'h00000000, rs);
      exp_f[i / 16] = 16'h0000;
    end
    $display("source map test done");
    for (int n = 0; n < 20; n++) begin
      for (int r = 0; r < 3; r++) begin
        d = xs();
        wr_strb = d[19:16];
        wr(8'(r * 4), d, rs);
        chk("wr_resp", {30'h0, rs}, 32'h00000000);
        // only implemented bits of strobed bytes take writes
        sm = {{8{d[17]}}, {8{d[16]}}};
        exp_f[r] = ((exp_f[r] & ~sm) | (d[15:0] & sm)) & msk[r];
      end
      d = xs();
      v = {d[15:0], xs()};
      src_u.pulse(v);
      for (int r = 0; r < 3; r++) exp_f[r] = exp_f[r] | (v[r*16+:16] & msk[r]);
      chk_all();
    end
    wr_strb = 4'hF;
    $display("random test done");
    // request on the clearing edge wins
    fork
      wr(8'h00, 32'h00000000, rs);
      begin
        @(posedge aclk);
        src_u.pulse(48'h000000000001);
      end
    join
    exp_f[0] = 16'h0001;
    chk_all();
    wr(8'h00, 32'h00000000, rs);
    wr(8'h10, 32'h00000007, rs);
    wr(8'h14, 32'h00000001, rs);
    src_u.pulse(48'h000000000001);
    @(negedge aclk);
    chk("irq_set", {31'h0, irq}, 32'h00000001);
    wr(8'h0C, 32'h00000000, rs);
    chk("status_wr_resp", {30'h0, rs}, 32'h00000000);
    rd(8'h0C, d, rs);
    chk("status", d, 32'h00000001);
    wr(8'h14, 32'h00000000, rs);
    @(negedge aclk);
    chk("irq_masked", {31'h0, irq}, 32'h00000000);
    wr(8'h10, 32'h00000001, rs);
    wr(8'h14, 32'h00000001, rs);
    // request to a flag already set raises no event
    src_u.pulse(48'h000000000001);
    @(negedge aclk);
    chk("irq_cleared", {31'h0, irq}, 32'h00000000);
    rd(8'h14, d, rs);
    chk("enable_read", d, 32'h00000001);
    rd(8'h10, d, rs);
    chk("clear_read", d, 32'h00000000);
    wr(8'h20, 32'h00000007, rs);
    chk("unmapped_wr_resp", {30'h0, rs}, 32'h00000003);
    rd(8'h20, d, rs);
    chk("unmapped_resp", {30'h0, rs}, 32'h00000003);
    chk_all();
    $display("interrupt test done");
    report_and_stop();
  end
endmodule
